//--- fbc_map.svh
// constants for the flash bank command controller: offsets, fields, timings, table values
`ifndef FBC_MAP_SVH
`define FBC_MAP_SVH
`define FBC_AW 21
`define FBC_DW 16
// software register offsets
`define FBC_REG_CMD 8'h00
`define FBC_REG_STATUS 8'h04
`define FBC_REG_ADDR 8'h08
`define FBC_REG_WDATA 8'h0C
`define FBC_REG_RDATA 8'h10
`define FBC_REG_CHECK 8'h14
`define FBC_REG_TIDX 8'h18
`define FBC_REG_TDATA 8'h1C
// status fields
`define FBC_ST_BUSY 0
`define FBC_ST_MODE_LO 1
`define FBC_ST_SUSP 3
`define FBC_ST_REFUSED 4
`define FBC_ST_TMO 5
`define FBC_ST_CHKDONE 6
`define FBC_TMO_BIT 5
// bus timing, clock period and least times in ns
`define FBC_CLK_NS 20
`define FBC_T_WP_NS 35
`define FBC_T_WPH_NS 20
`define FBC_T_ACC_NS 70
`define FBC_WP_CYC ((`FBC_T_WP_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_WPH_CYC ((`FBC_T_WPH_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`define FBC_ACC_CYC ((`FBC_T_ACC_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
// command defaults, overridable per instance except FBC_LOW_MASK, which is used directly
`define FBC_UNLOCK_ADDR1 21'h000555
`define FBC_UNLOCK_ADDR2 21'h0002AA
`define FBC_UNLOCK_DATA1 16'h00AA
`define FBC_UNLOCK_DATA2 16'h0055
`define FBC_AUTOSEL_CMD 16'h0090
`define FBC_SEC_ENTER_CMD 16'h0088
`define FBC_SEC_EXIT_CMD 16'h0090
`define FBC_SEC_EXIT2_CMD 16'h0000
`define FBC_QUERY_ADDR 21'h000055
`define FBC_QUERY_CMD 16'h0098
`define FBC_RESET_CMD 16'h00F0
`define FBC_SUSPEND_CMD 16'h00B0
`define FBC_RESUME_CMD 16'h0030
`define FBC_LOW_MASK 21'h000FFF
// query locations and expected contents
`define FBC_LOC_EXT_PTR 21'h000015
`define FBC_LOC_EXT_BASE 7'h40
`define FBC_EXP_EXT_PTR 16'h0040
`define FBC_EXP_P 16'h0050
`define FBC_EXP_R 16'h0052
`define FBC_EXP_I 16'h0049
`define FBC_EXP_VER 16'h0031
`define FBC_EXP_UNLOCK 16'h0000
`define FBC_EXP_SUSPEND 16'h0002
`define FBC_EXP_ONE 16'h0001
`define FBC_EXP_SCHEME 16'h0004
`define FBC_EXP_BANK2_A 16'h0038
`define FBC_EXP_BANK2_B 16'h0030
`define FBC_EXP_BANK2_C 16'h0020
`define FBC_EXP_NONE 16'h0000
`define FBC_EXP_ACC_MIN 16'h0085
`define FBC_EXP_ACC_MAX 16'h0095
`define FBC_EXP_BOTTOM 16'h0002
`define FBC_EXP_TOP 16'h0003
`endif

//--- fbc_pkg.sv
// types shared by the flash bank command controller
package fbc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_STROBE = 3'b011,
    ST_HOLD = 3'b010, ST_GAP = 3'b110, ST_SAMPLE = 3'b111
  } fbc_state_t;
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_RESET = 4'h1, OP_AUTOSEL = 4'h2, OP_ID_MAKER = 4'h3,
    OP_ID_DEVICE = 4'h4, OP_ID_PROT = 4'h5, OP_SEC_ENTER = 4'h6, OP_SEC_EXIT = 4'h7,
    OP_QUERY = 4'h8, OP_READ = 4'h9, OP_WRITE = 4'hA, OP_SUSPEND = 4'hB, OP_RESUME = 4'hC
  } fbc_op_t;
  typedef enum logic [1:0] {MD_READ = 2'h0, MD_AUTOSEL = 2'h1, MD_SECURE = 2'h2} fbc_mode_t;
  typedef struct packed {
    logic is_read;
    logic last;
    logic [20:0] addr;
    logic [15:0] data;
  } fbc_step_t;
  typedef struct packed {
    logic [20:0] addr;
    logic [15:0] dq_o;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
  } fbc_pins_t;
endpackage

//--- fbc_table_mem.sv
// sixteen-word store for the extended query table readback
`timescale 1ns/1ps
module fbc_table_mem
  import fbc_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_we,
  input wire logic [3:0] i_waddr,
  input wire logic [15:0] i_wdata,
  input wire logic [3:0] i_raddr,
  output logic [15:0] o_rdata
);
  logic [15:0] mem [16];

  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

//--- fbc_host.sv
// host controller driving a dual-bank parallel flash through its pins
//
// Overview of operation
// - host writes reset after a timeout flag or to leave autoselect.
// - autoselect only to an idle bank, never while the other is busy.
// - two unlock writes then bank address with autoselect command.
// - three-cycle entry and four-cycle exit of the secured region.
`timescale 1ns/1ps
`include "fbc_map.svh"
module fbc_host
  import fbc_pkg::*;
#(
  parameter logic [20:0] P_UNLOCK_ADDR1 = `FBC_UNLOCK_ADDR1,
  parameter logic [20:0] P_UNLOCK_ADDR2 = `FBC_UNLOCK_ADDR2,
  parameter logic [15:0] P_UNLOCK_DATA1 = `FBC_UNLOCK_DATA1,
  parameter logic [15:0] P_UNLOCK_DATA2 = `FBC_UNLOCK_DATA2,
  parameter logic [15:0] P_AUTOSEL_CMD = `FBC_AUTOSEL_CMD,
  parameter logic [15:0] P_SEC_ENTER_CMD = `FBC_SEC_ENTER_CMD,
  parameter logic [15:0] P_SEC_EXIT_CMD = `FBC_SEC_EXIT_CMD,
  parameter logic [15:0] P_SEC_EXIT2_CMD = `FBC_SEC_EXIT2_CMD,
  parameter logic [20:0] P_QUERY_ADDR = `FBC_QUERY_ADDR,
  parameter logic [15:0] P_QUERY_CMD = `FBC_QUERY_CMD,
  parameter logic [15:0] P_RESET_CMD = `FBC_RESET_CMD,
  parameter logic [15:0] P_SUSPEND_CMD = `FBC_SUSPEND_CMD,
  parameter logic [15:0] P_RESUME_CMD = `FBC_RESUME_CMD
)(
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_busy,
  output logic [20:0] o_flash_addr,
  output logic [15:0] o_flash_dq_o,
  output logic o_flash_dq_oe,
  input wire logic [15:0] i_flash_dq_i,
  output logic o_flash_ce_n,
  output logic o_flash_we_n,
  output logic o_flash_oe_n,
  input wire logic i_flash_busy_n
);
  localparam fbc_pins_t PINS_IDLE = '{addr: '0, dq_o: '0, dq_oe: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
  localparam logic [2:0] WP_LAST = 3'(`FBC_WP_CYC - 1);
  localparam logic [2:0] WPH_LAST = 3'(`FBC_WPH_CYC - 1);
  localparam logic [2:0] ACC_LAST = 3'(`FBC_ACC_CYC - 1);

  fbc_state_t state, next_state;
  fbc_op_t op, next_op;
  fbc_mode_t mode, next_mode;
  fbc_pins_t pins, next_pins;
  logic [4:0] idx, next_idx;
  logic [2:0] cnt, next_cnt;
  logic [2:0] wecnt, next_wecnt;
  logic susp, next_susp, refused, next_refused, tmo, next_tmo;
  logic auto_rst, next_auto_rst, chk_done, next_chk_done, busy_q, next_busy_q;
  logic [16:0] chk_bad, next_chk_bad;
  logic [15:0] rd_last, next_rd_last;
  logic [20:0] addr_reg, next_addr_reg;
  logic [15:0] wdata_reg, next_wdata_reg;
  logic [3:0] tidx, next_tidx;
  logic [31:0] rdata, next_rdata;
  logic tbl_we;
  logic [15:0] tbl_rdata;
  fbc_step_t cur;
  fbc_op_t go;
  logic fin, capture;

  // one bus cycle of a command sequence
  function automatic fbc_step_t step_of(input fbc_op_t o, input logic [4:0] i, input logic [20:0] t,
                                        input logic [15:0] wd);
    fbc_step_t s;
    logic [20:0] bank_unlock;
    s = '{is_read: 1'b0, last: 1'b1, addr: t, data: P_RESET_CMD};
    bank_unlock = (t & ~`FBC_LOW_MASK) | P_UNLOCK_ADDR1;
    case (o)
      OP_AUTOSEL, OP_SEC_ENTER, OP_SEC_EXIT: begin
        s.last = (o == OP_SEC_EXIT) ? (i == 5'd3) : (i == 5'd2);
        case (i)
          5'd0: begin
            s.addr = P_UNLOCK_ADDR1;
            s.data = P_UNLOCK_DATA1;
          end
          5'd1: begin
            s.addr = P_UNLOCK_ADDR2;
            s.data = P_UNLOCK_DATA2;
          end
          5'd2: begin
            s.addr = (o == OP_AUTOSEL) ? bank_unlock : P_UNLOCK_ADDR1;
            s.data = (o == OP_AUTOSEL) ? P_AUTOSEL_CMD : (o == OP_SEC_ENTER) ? P_SEC_ENTER_CMD : P_SEC_EXIT_CMD;
          end
          default: s.data = P_SEC_EXIT2_CMD;
        endcase
      end
      OP_ID_MAKER, OP_ID_DEVICE, OP_ID_PROT: begin
        s.is_read = 1'b1;
        s.addr = {t[20:8], 8'h00} | {19'h0, o[1:0] - 2'h3};
      end
      OP_QUERY: begin
        s.last = (i == 5'd18);
        s.is_read = (i != 5'd0) && (i != 5'd18);
        if (i == 5'd0) begin
          s.addr = P_QUERY_ADDR;
          s.data = P_QUERY_CMD;
        end else if (i == 5'd1) begin
          s.addr = `FBC_LOC_EXT_PTR;
        end else if (i != 5'd18) begin
          s.addr = {14'h0, `FBC_LOC_EXT_BASE + {2'b00, i} - 7'd2};
        end
      end
      OP_READ: s.is_read = 1'b1;
      OP_WRITE: s.data = wd;
      OP_SUSPEND: s.data = P_SUSPEND_CMD;
      OP_RESUME: s.data = P_RESUME_CMD;
      default: s.data = P_RESET_CMD;
    endcase
    return s;
  endfunction

  // expected query contents; step 1 is word 15h, steps 2..17 words 40h..4Fh
  function automatic logic exp_ok(input logic [4:0] i, input logic [15:0] d);
    logic [6:0] loc;
    logic ok;
    loc = `FBC_LOC_EXT_BASE + {2'b00, i} - 7'd2;
    ok = 1'b1;
    if (i == 5'd1) begin
      ok = (d == `FBC_EXP_EXT_PTR);
    end else begin
      case (loc)
        7'h40: ok = (d == `FBC_EXP_P);
        7'h41: ok = (d == `FBC_EXP_R);
        7'h42: ok = (d == `FBC_EXP_I);
        7'h43, 7'h44: ok = (d == `FBC_EXP_VER);
        7'h45: ok = (d == `FBC_EXP_UNLOCK);
        7'h46: ok = (d == `FBC_EXP_SUSPEND);
        7'h47, 7'h48: ok = (d == `FBC_EXP_ONE);
        7'h49: ok = (d == `FBC_EXP_SCHEME);
        7'h4A: ok = (d == `FBC_EXP_BANK2_A) || (d == `FBC_EXP_BANK2_B) || (d == `FBC_EXP_BANK2_C);
        7'h4B, 7'h4C: ok = (d == `FBC_EXP_NONE);
        7'h4D: ok = (d == `FBC_EXP_ACC_MIN);
        7'h4E: ok = (d == `FBC_EXP_ACC_MAX);
        7'h4F: ok = (d == `FBC_EXP_BOTTOM) || (d == `FBC_EXP_TOP);
        default: ok = 1'b1;
      endcase
    end
    return ok;
  endfunction

  // refusals protect the device from sequences it would misread
  function automatic logic refuse(input fbc_op_t o, input fbc_mode_t m, input logic ready, input logic t);
    logic r;
    r = (o > OP_RESUME);
    if (o == OP_AUTOSEL) r = !ready || (m != MD_READ);
    if ((o == OP_SEC_ENTER) || (o == OP_SEC_EXIT)) r = !ready;
    if ((o == OP_ID_MAKER) || (o == OP_ID_DEVICE) || (o == OP_ID_PROT)) r = (m != MD_AUTOSEL);
    if (o == OP_RESET) r = !ready && !t;
    return r;
  endfunction

  assign cur = step_of(op, idx, addr_reg, wdata_reg);
  assign fin = (state == ST_GAP) && (cnt == WPH_LAST) && cur.last;
  assign capture = (state == ST_SAMPLE) && (cnt == ACC_LAST);
  assign tbl_we = capture && (op == OP_QUERY) && (idx >= 5'd2);
  assign go = auto_rst ? OP_RESET : (i_wr && (i_addr == `FBC_REG_CMD)) ? fbc_op_t'(i_wdata[3:0]) : OP_NONE;

  always_comb begin
    next_state = state;
    next_op = op;
    next_mode = mode;
    next_pins = pins;
    next_idx = idx;
    next_cnt = cnt;
    next_wecnt = wecnt;
    next_susp = susp;
    next_refused = refused;
    next_tmo = tmo;
    next_auto_rst = auto_rst;
    next_chk_done = chk_done;
    next_chk_bad = chk_bad;
    next_rd_last = rd_last;
    next_busy_q = i_flash_busy_n;
    // clears first so that a set in the same cycle wins
    if (i_wr && (i_addr == `FBC_REG_STATUS)) begin
      next_refused = refused & ~i_wdata[`FBC_ST_REFUSED];
      next_tmo = tmo & ~i_wdata[`FBC_ST_TMO];
    end
    if (!busy_q && i_flash_busy_n) begin
      next_mode = MD_READ;
    end
    // only software commands count as refused; the queued reset is not one
    if (i_wr && (i_addr == `FBC_REG_CMD) && (i_wdata[3:0] != 4'h0) && ((state != ST_IDLE) || auto_rst)) begin
      next_refused = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        next_pins = PINS_IDLE;
        if (go != OP_NONE) begin
          if (refuse(go, mode, i_flash_busy_n, tmo || auto_rst)) begin
            next_refused = 1'b1;
          end else begin
            next_op = go;
            next_idx = 5'd0;
            next_wecnt = 3'd0;
            next_auto_rst = 1'b0;
            next_state = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // chip select and address lead the write strobe by a cycle
        next_pins.addr = cur.addr;
        next_pins.ce_n = 1'b0;
        next_pins.dq_o = cur.data;
        next_pins.dq_oe = !cur.is_read;
        next_pins.oe_n = !cur.is_read;
        next_cnt = 3'd0;
        next_state = cur.is_read ? ST_SAMPLE : ST_STROBE;
      end
      ST_STROBE: begin
        next_pins.we_n = 1'b0;
        next_cnt = cnt + 3'd1;
        if (cnt == 3'd0) begin
          next_wecnt = wecnt + 3'd1;
        end
        if (cnt == WP_LAST) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // write strobe rises before chip select, data still driven
        next_pins.we_n = 1'b1;
        next_cnt = 3'd0;
        next_state = ST_GAP;
      end
      ST_SAMPLE: begin
        next_cnt = cnt + 3'd1;
        if (capture) begin
          next_rd_last = i_flash_dq_i;
          next_pins.oe_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt = 3'd0;
          next_state = ST_GAP;
          if ((op == OP_QUERY) && (idx != 5'd0)) begin
            next_chk_bad[idx - 5'd1] = !exp_ok(idx, i_flash_dq_i);
          end
          if (!i_flash_busy_n && i_flash_dq_i[`FBC_TMO_BIT]) begin
            next_tmo = 1'b1;
            next_auto_rst = 1'b1;
          end
        end
      end
      default: begin
        next_pins.ce_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        next_pins.oe_n = 1'b1;
        next_cnt = cnt + 3'd1;
        if (cnt == WPH_LAST) begin
          next_idx = idx + 5'd1;
          next_state = cur.last ? ST_IDLE : ST_SETUP;
        end
        if (fin) begin
          case (op)
            OP_RESET, OP_WRITE, OP_SEC_EXIT: next_mode = MD_READ;
            OP_AUTOSEL: next_mode = MD_AUTOSEL;
            OP_SEC_ENTER: next_mode = MD_SECURE;
            OP_QUERY: begin
              next_mode = MD_READ;
              next_chk_done = 1'b1;
            end
            OP_SUSPEND: next_susp = 1'b1;
            OP_RESUME: next_susp = 1'b0;
            // keep a busy-end return to read array
            default: begin
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
      op <= OP_NONE;
      mode <= MD_READ;
      pins <= PINS_IDLE;
      idx <= 5'd0;
      cnt <= 3'd0;
      wecnt <= 3'd0;
      susp <= 1'b0;
      refused <= 1'b0;
      tmo <= 1'b0;
      auto_rst <= 1'b0;
      chk_done <= 1'b0;
      chk_bad <= 17'h00000;
      rd_last <= 16'h0000;
      busy_q <= 1'b1;
    end else begin
      state <= next_state;
      op <= next_op;
      mode <= next_mode;
      pins <= next_pins;
      idx <= next_idx;
      cnt <= next_cnt;
      wecnt <= next_wecnt;
      susp <= next_susp;
      refused <= next_refused;
      tmo <= next_tmo;
      auto_rst <= next_auto_rst;
      chk_done <= next_chk_done;
      chk_bad <= next_chk_bad;
      rd_last <= next_rd_last;
      busy_q <= next_busy_q;
    end
  end

  // software registers
  always_comb begin
    next_addr_reg = addr_reg;
    next_wdata_reg = wdata_reg;
    next_tidx = tidx;
    next_rdata = 32'h00000000;
    if (i_wr) begin
      if (i_addr == `FBC_REG_ADDR) begin
        next_addr_reg = i_wdata[20:0];
      end else if (i_addr == `FBC_REG_WDATA) begin
        next_wdata_reg = i_wdata[15:0];
      end else if (i_addr == `FBC_REG_TIDX) begin
        next_tidx = i_wdata[3:0];
      end
    end
    if (i_rd) begin
      if (i_addr == `FBC_REG_CMD) begin
        next_rdata = {28'h0, op};
      end else if (i_addr == `FBC_REG_STATUS) begin
        next_rdata = {25'h0, chk_done, tmo, refused, susp, mode, state != ST_IDLE};
      end else if (i_addr == `FBC_REG_ADDR) begin
        next_rdata = {11'h0, addr_reg};
      end else if (i_addr == `FBC_REG_WDATA) begin
        next_rdata = {16'h0, wdata_reg};
      end else if (i_addr == `FBC_REG_RDATA) begin
        next_rdata = {16'h0, rd_last};
      end else if (i_addr == `FBC_REG_CHECK) begin
        next_rdata = {15'h0, chk_bad};
      end else if (i_addr == `FBC_REG_TIDX) begin
        next_rdata = {28'h0, tidx};
      end else if (i_addr == `FBC_REG_TDATA) begin
        next_rdata = {16'h0, tbl_rdata};
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_reg <= 21'h000000;
      wdata_reg <= 16'h0000;
      tidx <= 4'h0;
      rdata <= 32'h00000000;
      o_busy <= 1'b0;
    end else begin
      addr_reg <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      tidx <= next_tidx;
      rdata <= next_rdata;
      o_busy <= (next_state != ST_IDLE);
    end
  end

  fbc_table_mem u_table (
    .i_sys_clk(i_sys_clk),
    .i_we(tbl_we),
    .i_waddr(idx[3:0] - 4'h2),
    .i_wdata(i_flash_dq_i),
    .i_raddr(tidx),
    .o_rdata(tbl_rdata)
  );

  assign o_rdata = rdata;
  assign o_flash_addr = pins.addr;
  assign o_flash_dq_o = pins.dq_o;
  assign o_flash_dq_oe = pins.dq_oe;
  assign o_flash_ce_n = pins.ce_n;
  assign o_flash_we_n = pins.we_n;
  assign o_flash_oe_n = pins.oe_n;

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_WE_UNDER_CE: assert property (!o_flash_we_n |-> !o_flash_ce_n)
    else $error("write strobe low without chip select");
  AST_ADDR_STEADY: assert property ($fell(o_flash_we_n) |=> $stable(o_flash_addr) [*2])
    else $error("address moved during write pulse");
  AST_DATA_AT_RISE: assert property ($rose(o_flash_we_n) |-> o_flash_dq_oe && !o_flash_ce_n && $stable(o_flash_dq_o))
    else $error("data not held at write strobe rise");
  AST_AUTOSEL_THREE: assert property (fin && op == OP_AUTOSEL |-> wecnt == 3'd3 ##1 mode == MD_AUTOSEL)
    else $error("autoselect entry not three writes");
  AST_SEC_EXIT_FOUR: assert property (fin && op == OP_SEC_EXIT |-> wecnt == 3'd4 ##1 mode == MD_READ)
    else $error("secured exit not four writes");
  AST_REFUSE_AUTOSEL: assert property (state == ST_IDLE && go == OP_AUTOSEL && !i_flash_busy_n
      |=> refused && state == ST_IDLE)
    else $error("autoselect started while device busy");
  AST_RESET_KEEPS_SUSP: assert property (fin && op == OP_RESET |=> mode == MD_READ && susp == $past(susp))
    else $error("reset lost suspend state");
  AST_TIMEOUT_RESET: assert property (capture && cur.last && !i_flash_busy_n && i_flash_dq_i[`FBC_TMO_BIT]
      |-> ##[1:4] (state == ST_SETUP && op == OP_RESET))
    else $error("no reset after timeout flag");
  AST_EXT_PTR_CHECK: assert property (capture && op == OP_QUERY && idx == 5'd1 && i_flash_dq_i != `FBC_EXP_EXT_PTR
      |=> chk_bad[0])
    else $error("bad extended pointer not flagged");
  AST_SIGNATURE_CHECK: assert property (capture && op == OP_QUERY && idx == 5'd2 && i_flash_dq_i != `FBC_EXP_P
      |=> chk_bad[1])
    else $error("bad signature not flagged");
  AST_BUSY_END_READ: assert property (!busy_q && i_flash_busy_n && !(fin && (op == OP_AUTOSEL || op == OP_SEC_ENTER))
      |=> mode == MD_READ)
    else $error("mode not read after busy end");

  COV_AUTOSEL: cover property (fin && op == OP_AUTOSEL);
  COV_QUERY: cover property (fin && op == OP_QUERY);
  COV_SEC_EXIT: cover property (fin && op == OP_SEC_EXIT);
  COV_TIMEOUT: cover property (auto_rst && state == ST_IDLE);
endmodule

//--- fbc_flash_model.sv
// behavioural flash device answering the host controller pins
`timescale 1ns/1ps
module fbc_flash_model #(
  parameter logic [15:0] P_MAKER = 16'h00A5, // arbitrary
  parameter logic [15:0] P_DEVICE = 16'h2B7E // arbitrary
)(
  input wire logic [20:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_busy,
  output logic [15:0] o_dq,
  output logic o_busy_n
);
  // mode 0 read array, 1 autoselect, 2 secure region, 3 query
  logic [1:0] mode = 2'h0;
  logic [1:0] cyc = 2'h0;
  logic [20:0] la = 21'h0;
  logic [15:0] val;
  logic [15:0] last = 16'h0;
  wire drive = !i_ce_n && !i_oe_n;
  assign o_busy_n = !i_busy;
  // no pull on dq, so a released bus shows the inverse of the last word
  assign o_dq = drive ? val : ~last;
  always @(val, drive) if (drive) last = val;
  always @(negedge i_we_n or negedge i_ce_n) if (!i_we_n && !i_ce_n) la <= i_addr;
  always @(posedge i_we_n or posedge i_ce_n) begin
    if (!i_we_n || !i_ce_n) begin
      if (i_dq == 16'h00F0) begin
        cyc <= 2'h0;
        if (mode != 2'h2) mode <= 2'h0;
      end else if (cyc == 2'h0 && la[11:0] == 12'h555 && i_dq == 16'h00AA) cyc <= 2'h1;
      else if (cyc == 2'h0 && la[11:0] == 12'h055 && i_dq == 16'h0098) mode <= 2'h3;
      else if (cyc == 2'h1 && la[11:0] == 12'h2AA && i_dq == 16'h0055) cyc <= 2'h2;
      else if (cyc == 2'h2 && la[11:0] == 12'h555 && i_dq == 16'h0088) begin
        mode <= 2'h2;
        cyc <= 2'h0;
      end else if (cyc == 2'h2 && la[11:0] == 12'h555 && i_dq == 16'h0090) begin
        cyc <= (mode == 2'h2) ? 2'h3 : 2'h0;
        if (mode != 2'h2) mode <= 2'h1;
      end else if (cyc == 2'h3 && i_dq == 16'h0000) begin
        mode <= 2'h0;
        cyc <= 2'h0;
      end else begin
        cyc <= 2'h0;
        if (mode != 2'h2) mode <= 2'h0;
      end
    end
  end
  always_comb begin
    val = i_addr[15:0] ^ 16'h5A5A;
    if (mode == 2'h1) begin
      case (i_addr[7:0])
        8'h00: val = P_MAKER;
        8'h01: val = P_DEVICE;
        8'h02: val = {15'h0, i_addr[20:12] == 9'h101};
        default: val = 16'h0000;
      endcase
    end else if (mode == 2'h2) val = 16'hE500 | {12'h0, i_addr[3:0]};
    else if (mode == 2'h3) begin
      case (i_addr[7:0])
        8'h15: val = 16'h0040;
        8'h40: val = 16'h0050;
        8'h41: val = 16'h0052;
        8'h42: val = 16'h0049;
        8'h43, 8'h44: val = 16'h0031;
        8'h46: val = 16'h0002;
        8'h47, 8'h48: val = 16'h0001;
        8'h49: val = 16'h0004;
        8'h4A: val = 16'h0038;
        8'h4D: val = 16'h0085;
        8'h4E: val = 16'h0095;
        8'h4F: val = 16'h0002;
        default: val = 16'h0000;
      endcase
    end
  end
endmodule

//--- test_fbc_host.sv
// self-checking bench for the flash bank host controller
`timescale 1ns/1ps
module test_fbc_host;
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary
  localparam logic [15:0] DEVICE = 16'h2B7E; // arbitrary
  localparam logic [15:0] EXP [16] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0031, 16'h0000, 16'h0002,
    16'h0001, 16'h0001, 16'h0004, 16'h0038, 16'h0000, 16'h0000, 16'h0085, 16'h0095, 16'h0002};
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic hold = 1'b0;
  logic [31:0] o_rdata, d;
  logic o_busy, o_flash_dq_oe, o_flash_ce_n, o_flash_we_n, o_flash_oe_n, i_flash_busy_n;
  logic [20:0] o_flash_addr;
  logic [15:0] o_flash_dq_o, i_flash_dq_i;
  int fails = 0;
  int n_tests = 0;
  int i;
  initial forever #10 i_sys_clk = ~i_sys_clk;
  fbc_host u_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_busy(o_busy), .o_flash_addr(o_flash_addr), .o_flash_dq_o(o_flash_dq_o),
    .o_flash_dq_oe(o_flash_dq_oe), .i_flash_dq_i(i_flash_dq_i), .o_flash_ce_n(o_flash_ce_n),
    .o_flash_we_n(o_flash_we_n), .o_flash_oe_n(o_flash_oe_n), .i_flash_busy_n(i_flash_busy_n));
  fbc_flash_model #(.P_MAKER(MAKER), .P_DEVICE(DEVICE)) u_flash (.i_addr(o_flash_addr),
    .i_dq(o_flash_dq_oe ? o_flash_dq_o : i_flash_dq_i), .i_ce_n(o_flash_ce_n), .i_we_n(o_flash_we_n),
    .i_oe_n(o_flash_oe_n), .i_busy(hold), .o_dq(i_flash_dq_i), .o_busy_n(i_flash_busy_n));
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  // bounded wait: a hung sequence counts as a mismatch
  task op(input logic [3:0] c);
    int k;
    wr(8'h00, {28'h0, c});
    #1;
    for (k = 0; k < 3000 && o_busy !== 1'b0; k++) @(posedge i_sys_clk) #1;
    if (k == 3000) fails++;
  endtask
  task opr(input logic [3:0] c, input logic [31:0] e);
    op(c);
    rd(8'h10, d);
    chk(d, e);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e);
    rd(8'h04, d);
    chk(d & m, e);
  endtask
  task end_sim;
    $display("tests %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    st(32'hFF, 32'h0);
    chk({31'h0, o_busy}, 32'h0);
    wr(8'h08, 32'h1234);
    opr(4'h9, 32'h1234 ^ 32'h5A5A);
    op(4'h8);
    st(32'h40, 32'h40);
    rd(8'h14, d);
    chk(d, 32'h0);
    for (i = 0; i < 16; i++) begin
      wr(8'h18, i);
      @(posedge i_sys_clk);
      rd(8'h1C, d);
      chk(d, {16'h0, EXP[i]});
    end
    chk({30'h0, u_flash.mode}, 32'h0);
    wr(8'h08, 32'h101000);
    op(4'h2);
    st(32'h6, 32'h2);
    opr(4'h3, {16'h0, MAKER});
    opr(4'h4, {16'h0, DEVICE});
    opr(4'h5, 32'h1);
    wr(8'h08, 32'h102000);
    opr(4'h5, 32'h0);
    op(4'h1);
    st(32'h6, 32'h0);
    chk({30'h0, u_flash.mode}, 32'h0);
    wr(8'h08, 32'h3);
    op(4'h6);
    st(32'h6, 32'h4);
    opr(4'h9, 32'hE503);
    op(4'h7);
    st(32'h6, 32'h0);
    opr(4'h9, 32'h3 ^ 32'h5A5A);
    // embedded work pending in the far bank: autoselect must be held back
    hold <= 1'b1;
    op(4'h2);
    st(32'h10, 32'h10);
    chk({30'h0, u_flash.mode}, 32'h0);
    hold <= 1'b0;
    wr(8'h04, 32'h10);
    st(32'h10, 32'h0);
    wr(8'h08, 32'h555);
    wr(8'h0C, 32'hAA);
    op(4'hA);
    chk({30'h0, u_flash.cyc}, 32'h1);
    wr(8'h0C, 32'h11);
    op(4'hA);
    chk({30'h0, u_flash.cyc}, 32'h0);
    // read with embedded work running and the timeout bit up: a reset must follow
    wr(8'h08, 32'h20);
    hold <= 1'b1;
    opr(4'h9, 32'h20 ^ 32'h5A5A);
    op(4'h0);
    st(32'h30, 32'h20);
    chk({30'h0, u_flash.mode}, 32'h0);
    hold <= 1'b0;
    wr(8'h04, 32'h20);
    st(32'h20, 32'h0);
    op(4'hB);
    st(32'h8, 32'h8);
    op(4'h1);
    st(32'hE, 32'h8);
    op(4'hC);
    st(32'h8, 32'h0);
    end_sim;
  end
endmodule
